// [rtl/host_memory_command_port.v]
// host memory command port: two byte registers, command engine
// assumes a synchronous host i/o strobe on clk, decoded address
// Notes on behaviour
// - result byte placed in parameter register
// - command only when command flag set
// - completion restores previous configuration byte
// - 10h/11h load pointer low/high bytes
// - 12h writes parameter to memory
// - 13h loads control byte
// - 18h/19h return pointer low/high byte
// - 1ah returns memory byte at pointer
// - 1bh returns one revision byte
// - 30h clears all receiver error counts
// - 31h-36h return six error counts
// - pointer 16 bits, control 8 bits
// - three revision reads, xxcc dddd format
// - unknown commands ignored, no state change
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_defs.vh"
module host_memory_command_port #(
  parameter MEM_ADDR_W = 16,
  parameter NUM_ERR = 6
) (
  input wire clk,
  input wire rstn,
  input wire [9:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [NUM_ERR-1:0] rx_error_pulse,
  output reg [7:0] io_rdata,
  output reg [7:0] control_byte,
  output reg command_busy
);
  // ========================================================
  // state
  // one-hot, so a stray code falls back to idle through the default
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  reg [2:0] state_reg;
  reg [7:0] param_reg;
  reg [7:0] config_reg;
  reg [7:0] saved_config_reg;
  reg [15:0] memory_pointer;
  reg [1:0] rev_pos_reg;
  // 64k bytes held here; a smaller MEM_ADDR_W ignores top pointer bits
  // no reset on the array: contents are unknown until written
  reg [7:0] mem [0:(1<<MEM_ADDR_W)-1];
  reg [7:0] mem_q;
  wire [7:0] err_count;
  // ========================================================
  // host address decode
  wire wr_param = io_wr && io_addr == `PARAM_RESPONSE_OFFSET;
  wire wr_config = io_wr && io_addr == `CONFIG_COMMAND_OFFSET;
  wire rd_param = io_rd && io_addr == `PARAM_RESPONSE_OFFSET;
  wire rd_config = io_rd && io_addr == `CONFIG_COMMAND_OFFSET;
  // ========================================================
  // command decode
  // the command is what config holds while busy; plain writes never
  // reach the engine because they leave the flag clear
  wire [7:0] cmd = config_reg;
  wire is_mem_cmd = cmd == `CMD_WRITE_DATA ||
    cmd == `CMD_READ_DATA;
  wire is_err_cmd = cmd >= `CMD_READ_DISABLE_ERRORS &&
    cmd <= `CMD_READ_PROTOCOL_ERRORS;
  // 31h..36h map to counters 0..5
  wire [2:0] err_sel = cmd[2:0] - 3'd1;
  // clearing in exec means a read issued next already sees zeros
  wire do_clear = state_reg == ST_EXEC &&
    cmd == `CMD_CLEAR_ERROR_COUNTS;
  // ========================================================
  // error counters
  // clear wins over a pulse in the same cycle; counts saturate at ffh
  error_counters #(.N(NUM_ERR)) u_err (
    .clk(clk),
    .rstn(rstn),
    .clear(do_clear),
    .error_pulse(rx_error_pulse),
    .select(err_sel),
    .count(err_count)
  );
  // ========================================================
  // data memory, synchronous read
  // the read port runs every edge, so mem_q follows the pointer
  // one edge late; the engine waits out that edge in exec
  always @(posedge clk) begin
    if (state_reg == ST_EXEC && cmd == `CMD_WRITE_DATA) begin
      mem[memory_pointer[MEM_ADDR_W-1:0]] <= param_reg;
    end
    mem_q <= mem[memory_pointer[MEM_ADDR_W-1:0]];
  end
  // ========================================================
  // revision byte: two reserved bits, position, digit
  // position 3 never occurs; the count wraps after position 2
  reg [3:0] rev_digit;
  always @* begin
    case (rev_pos_reg)
      2'd0: rev_digit = `REV_DIGIT0;
      2'd1: rev_digit = `REV_DIGIT1;
      default: rev_digit = `REV_DIGIT2;
    endcase
  end
  wire [7:0] rev_byte = {2'b00, rev_pos_reg,
    rev_digit};
  // ========================================================
  // command engine
  always @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      param_reg <= 8'h00;
      config_reg <= `CONFIG_RESET;
      saved_config_reg <= `CONFIG_RESET;
      memory_pointer <= 16'h0000;
      control_byte <= `CONTROL_RESET;
      rev_pos_reg <= 2'd0;
      command_busy <= 1'b0;
      // error counts clear in their own module on the same reset
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // host writes only accepted while no command runs
          // the parameter may be rewritten any number of times first
          if (wr_param) begin
            param_reg <= io_wdata;
          end
          if (wr_config) begin
            config_reg <= io_wdata;
            if (io_wdata[`COMMAND_FLAG_BIT]) begin
              state_reg <= ST_EXEC;
              command_busy <= 1'b1;
            end else begin
              // kept so that completion can put the setting back
              saved_config_reg <= io_wdata;
            end
          end
        end
        ST_EXEC: begin
          // one cycle for mem_q to settle before a read answers
          state_reg <= ST_DONE;
          // commands with no response leave the parameter byte alone
          case (cmd)
            `CMD_LOAD_POINTER_LOW: begin
              memory_pointer[7:0] <= param_reg;
            end
            `CMD_LOAD_POINTER_HIGH: begin
              memory_pointer[15:8] <= param_reg;
            end
            `CMD_LOAD_CONTROL_BYTE: begin
              control_byte <= param_reg;
            end
            `CMD_READ_POINTER_LOW: begin
              param_reg <= memory_pointer[7:0];
            end
            `CMD_READ_POINTER_HIGH: begin
              param_reg <= memory_pointer[15:8];
            end
            `CMD_READ_REVISION: begin
              param_reg <= rev_byte;
              // three reads walk positions 0, 1, 2, then start over
              if (rev_pos_reg == 2'd2) begin
                rev_pos_reg <= 2'd0;
              end else begin
                rev_pos_reg <= rev_pos_reg + 2'd1;
              end
            end
            default: begin
              // err_count is combinational from the counters
              if (is_err_cmd) begin
                param_reg <= err_count;
              end
              // anything else leaves state alone
            end
          endcase
        end
        ST_DONE: begin
          // mem_q lags the pointer by one edge, so the read answers here
          if (cmd == `CMD_READ_DATA) begin
            param_reg <= mem_q;
          end
          // step after the access so the next command sees the new address
          if (is_mem_cmd && control_byte[`AUTO_INC_BIT]) begin
            // 16-bit add wraps at ffffh
            memory_pointer <= memory_pointer + 16'h0001;
          end
          // restoring the setting also clears the command flag
          config_reg <= saved_config_reg;
          // busy drops on the same edge, so both tell the same story
          command_busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // ========================================================
  // read data, registered; host polls the flag
  // a read while busy shows the flag set, which is what the host polls
  // idle cycles drive zero so a stale byte never looks like an answer
  // a read of any other address also answers zero
  always @(posedge clk) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
    end else if (rd_param) begin
      io_rdata <= param_reg;
    end else if (rd_config) begin
      io_rdata <= config_reg;
    end else begin
      io_rdata <= 8'h00;
    end
  end
endmodule // host_memory_command_port
`default_nettype wire

// [pkg/host_cmd_defs.vh]
// constants for the host memory command port
// assumes inclusion by bare name from the rtl files
`ifndef HOST_CMD_DEFS_VH
`define HOST_CMD_DEFS_VH
// ==========================================================
// register offsets on the host i/o bus
`define PARAM_RESPONSE_OFFSET 10'h2db
`define CONFIG_COMMAND_OFFSET 10'h2dc
// ==========================================================
// configuration and control byte fields
`define COMMAND_FLAG_BIT 4
`define CONFIG_RESET 8'h00
`define CONTROL_RESET 8'h00
`define AUTO_INC_BIT 0
// ==========================================================
// command codes
`define CMD_LOAD_POINTER_LOW 8'h10
`define CMD_LOAD_POINTER_HIGH 8'h11
`define CMD_WRITE_DATA 8'h12
`define CMD_LOAD_CONTROL_BYTE 8'h13
`define CMD_READ_POINTER_LOW 8'h18
`define CMD_READ_POINTER_HIGH 8'h19
`define CMD_READ_DATA 8'h1a
`define CMD_READ_REVISION 8'h1b
`define CMD_CLEAR_ERROR_COUNTS 8'h30
`define CMD_READ_DISABLE_ERRORS 8'h31
`define CMD_READ_MIDBIT_LOSS_ERRORS 8'h32
`define CMD_READ_BAD_ENDING_ERRORS 8'h33
`define CMD_READ_PARITY_ERRORS 8'h34
`define CMD_READ_OVERFLOW_ERRORS 8'h35
`define CMD_READ_PROTOCOL_ERRORS 8'h36
// ==========================================================
// revision digits, arbitrary values
`define REV_DIGIT0 4'h1
`define REV_DIGIT1 4'h0
`define REV_DIGIT2 4'h0
`define NUM_ERROR_KINDS 6
`endif

// [rtl/error_counters.v]
// receiver error counters, six saturating 8-bit counts
// assumes one-cycle error pulses from receiver logic on clk
`timescale 1ns/1ps
`default_nettype none
module error_counters #(
  parameter N = 6
) (
  input wire clk,
  input wire rstn,
  input wire clear,
  input wire [N-1:0] error_pulse,
  input wire [2:0] select,
  output reg [7:0] count
);
  // ========================================================
  // counters
  reg [7:0] cnt_reg [0:N-1];
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_cnt
      always @(posedge clk) begin
        if (!rstn || clear) begin
          cnt_reg[g] <= 8'h00;
        end else if (error_pulse[g] && cnt_reg[g] != 8'hff) begin
          // saturate so a busy line never wraps to small counts
          cnt_reg[g] <= cnt_reg[g] + 8'h01;
        end
      end
    end
  endgenerate
  always @* begin
    if (select < N) begin
      count = cnt_reg[select];
    end else begin
      count = 8'h00;
    end
  end
endmodule // error_counters
`default_nettype wire

// [verif/port_rules_asserts.sv]
// checker for the host command port, bound to its top module
// assumes host strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module port_rules (
  input wire clk,
  input wire rstn,
  input wire [9:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire [7:0] control_byte,
  input wire command_busy
);
  // ====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // writes during busy are refused, so only idle writes count
  wire cfg_wr = io_wr && io_addr == 10'h2dc && !command_busy;
  chk_busy_start: assert property (cfg_wr && io_wdata[4]
    |=> command_busy)
    else $error("command did not start");
  chk_plain_cfg: assert property (cfg_wr && !io_wdata[4]
    |=> !command_busy)
    else $error("plain write started a command");
  chk_busy_two: assert property ($rose(command_busy)
    |=> command_busy ##1 !command_busy)
    else $error("busy length wrong");
  chk_busy_bound: assert property (command_busy
    |-> ##[1:2] !command_busy)
    else $error("busy too long");
  chk_rdata_zero: assert property (!$past(io_rd)
    |-> io_rdata == 8'h00)
    else $error("read data without read");
  chk_flag_clear: assert property (io_rd && io_addr == 10'h2dc
    && !command_busy |=> !io_rdata[4])
    else $error("flag still set when idle");
  chk_ctrl_cause: assert property ($changed(control_byte)
    |-> $past(command_busy))
    else $error("control changed outside command");
  chk_cfg_echo: assert property (cfg_wr && !io_wdata[4]
    ##2 io_rd && io_addr == 10'h2dc |=> io_rdata == $past(io_wdata, 3))
    else $error("configuration not kept");
  cover property (cfg_wr && io_wdata[4]);
  cover property ($fell(command_busy));
  cover property ($changed(control_byte));
endmodule // port_rules
bind host_memory_command_port port_rules u_port_rules (.clk(clk),
  .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .control_byte(control_byte),
  .command_busy(command_busy));
`default_nettype wire

// [verif/host_pc_model.sv]
// host side model: single byte writes and reads on the i/o strobes
// assumes each task is entered just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_pc_model (
  input wire clk,
  output logic [9:0] io_addr = 10'h000,
  output logic io_wr = 1'b0,
  output logic io_rd = 1'b0,
  output logic [7:0] io_wdata = 8'h00,
  input wire [7:0] io_rdata
);
  // ====
  // bus cycles
  // data is inverted after a write so a stale byte never matches by luck
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask
endmodule // host_pc_model
`default_nettype wire

// [verif/host_memory_command_port_bench.sv]
// self-checking bench for the host memory command port
// assumes the host model drives every host strobe
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_defs.vh"
module host_memory_command_port_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] rx_error_pulse = 6'h00;
  logic [7:0] r;
  wire [9:0] io_addr;
  wire io_wr, io_rd, command_busy;
  wire [7:0] io_wdata, io_rdata, control_byte;
  int err_total = 0;
  int comparisons = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  host_memory_command_port u_host_memory_command_port (.clk(clk),
    .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .rx_error_pulse(rx_error_pulse),
    .io_rdata(io_rdata), .control_byte(control_byte),
    .command_busy(command_busy));
  host_pc_model u_host_pc_model (.clk(clk), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
  // ====
  // helpers
  task automatic cmp(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // polling is bounded; a flag that never clears ends the run
  task automatic cmd(input logic [7:0] c, p, output logic [7:0] o);
    logic [7:0] v;
    u_host_pc_model.wr(10'h2db, p);
    u_host_pc_model.wr(10'h2dc, c);
    for (int i = 0; i < 8; i++) begin
      u_host_pc_model.rd(10'h2dc, v);
      if (v[4] === 1'b0) break;
    end
    if (v[4] !== 1'b0) begin
      err_total++;
      results();
    end
    u_host_pc_model.rd(10'h2db, o);
  endtask
  task automatic set_ptr(input logic [15:0] a);
    cmd(8'h10, a[7:0], r);
    cmd(8'h11, a[15:8], r);
  endtask
  task automatic chk_ptr(input logic [15:0] a);
    cmd(8'h18, 8'h00, r);
    cmp("ptr low", a[7:0], r);
    cmd(8'h19, 8'h00, r);
    cmp("ptr high", a[15:8], r);
  endtask
  // ====
  // scenarios
  task automatic t_memory;
    cmd(8'h13, 8'h01, r);
    cmp("control", 8'h01, control_byte);
    set_ptr(16'hffff);
    cmd(8'h12, 8'ha5, r);
    chk_ptr(16'h0000);
    set_ptr(16'hffff);
    cmd(8'h1a, 8'h00, r);
    cmp("mem byte", 8'ha5, r);
    cmd(8'h13, 8'h00, r);
    cmd(8'h1a, 8'h00, r);
    chk_ptr(16'h0000);
  endtask
  task automatic t_revision;
    logic [3:0] dig [3] = '{`REV_DIGIT0, `REV_DIGIT1, `REV_DIGIT2};
    for (int i = 0; i < 3; i++) begin
      cmd(8'h1b, 8'h00, r);
      cmp("revision", {2'b00, i[1:0], dig[i]}, r & 8'h3f);
    end
  endtask
  task automatic t_errors;
    for (int k = 0; k < 6; k++) begin
      repeat (k + 1) begin
        rx_error_pulse <= 6'h01 << k;
        @(posedge clk);
        rx_error_pulse <= 6'h00;
        @(posedge clk);
      end
    end
    for (int k = 0; k < 6; k++) begin
      cmd(8'h31 + k[7:0], 8'h00, r);
      cmp("err count", k[7:0] + 8'h01, r);
    end
    cmd(8'h30, 8'h00, r);
    for (int k = 0; k < 6; k++) begin
      cmd(8'h31 + k[7:0], 8'h00, r);
      cmp("cleared", 8'h00, r);
    end
  endtask
  task automatic t_unknown;
    set_ptr(16'h0042);
    cmd(8'h1f, 8'h77, r);
    cmd(8'h3f, 8'h77, r);
    chk_ptr(16'h0042);
    cmp("control kept", 8'h00, control_byte);
    u_host_pc_model.wr(10'h2dc, 8'h05);
    u_host_pc_model.rd(10'h2dc, r);
    cmp("config", 8'h05, r);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_memory();
    t_revision();
    t_errors();
    t_unknown();
    results();
  end
endmodule // host_memory_command_port_bench
`default_nettype wire
